// ---- crc_pkg.sv ----
// Package of constants and types for the converter remote control
package crc_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CMD   = 8'h04;
   localparam logic [7:0] ADDR_FREQ  = 8'h08;
   localparam logic [7:0] ADDR_ATT   = 8'h0C;
   localparam logic [7:0] ADDR_STAT  = 8'h10;
   localparam logic [7:0] ADDR_POLL  = 8'h14;
   localparam logic [7:0] ADDR_LFREQ = 8'h18;
   localparam logic [7:0] ADDR_RESP  = 8'h1C;
   localparam logic [7:0] ADDR_MSEL  = 8'h20;
   localparam logic [7:0] ADDR_MFREQ = 8'h24;
   localparam logic [7:0] ADDR_MATT  = 8'h28;
   // Control and status register fields, control reset value
   localparam int         CTRL_SRQ_EN_BIT = 0;
   localparam int         CTRL_REMOTE_BIT = 1;
   localparam int         CTRL_MUTE_BIT   = 2;
   localparam logic [2:0] CTRL_RESET      = 3'h0;
   localparam int         STAT_ERR_BIT    = 2;
   // Message characters
   localparam logic [7:0] CH_C = 8'h43;
   localparam logic [7:0] CH_F = 8'h46;
   localparam logic [7:0] CH_T = 8'h54;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   // Field widths and digit counts
   localparam int         FREQ_W   = 27;
   localparam int         ATT_W    = 10;
   localparam int         MEM_W    = FREQ_W + ATT_W;
   localparam logic [3:0] FDIG_MIN = 4'h7;
   localparam logic [3:0] FDIG_MAX = 4'h8;
   localparam logic [1:0] ADIG_LAST = 2'h2;
   // Response codes and status byte
   localparam logic [7:0] RESP_OK    = 8'h00;
   localparam logic [7:0] RESP_RANGE = 8'h62;
   localparam int         POLL_RQS_BIT = 6;
   // Band limits in kHz, and contact filter timing
   localparam logic [2:0][FREQ_W-1:0] BAND_LO =
      {27'hD9_7010, 27'hD5_9F80, 27'hD1_CEF0};
   localparam logic [2:0][FREQ_W-1:0] BAND_HI =
      {27'hDD_40A0, 27'hD9_7010, 27'hD5_9F80};
   localparam int         CLK_PERIOD_NS = 100;
   localparam int         DEB_TIME_NS   = 500;
   localparam int         DEB_CYCLES    =
      (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] DEB_LAST      = 3'(DEB_CYCLES - 1);

   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_CMD  = 2'b01,
      P_FREQ = 2'b10,
      P_ATT  = 2'b11
   } crc_parse_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } crc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } crc_apb_rsp_t;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic [2:0] cnt;
      logic       q;
   } crc_deb_t;

   typedef struct packed {
      logic [31:0][MEM_W-1:0] mem;
      logic [MEM_W-1:0]       rdata;
   } crc_mem_t;

   typedef struct packed {
      crc_apb_rsp_t              rsp;
      logic [2:0]                ctrl;
      crc_parse_t                pstate;
      logic [3:0]                fcnt;
      logic [1:0]                acnt;
      logic [FREQ_W-1:0]         fbuf;
      logic [ATT_W-1:0]          abuf;
      logic [FREQ_W-1:0]         freq;
      logic [ATT_W-1:0]          att;
      logic [2:0][FREQ_W-1:0]    band_last;
      logic [1:0]                band_idx;
      logic                      band_ok;
      logic                      mute;
      logic                      srq;
      logic [2:0]                fault_idx;
      logic [5:0]                alarm_prev;
      logic [7:0]                resp;
      logic                      cmd_err;
      logic [4:0]                bcd_loc;
      logic [5:0]                bcd_stat_n;
      logic                      recall_pend;
      logic [4:0]                mem_sel;
      logic [FREQ_W-1:0]         mem_freq;
   } crc_state_t;
endpackage

// ---- crc_debounce.sv ----
// Two-flop synchroniser and stability filter for contact inputs
module crc_debounce
   import crc_pkg::*;
#(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Raw and filtered levels
   input  wire logic [W-1:0] raw,
   output      logic [W-1:0] stable
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         crc_deb_t d_reg;
         crc_deb_t d_next;

         // Filtered level changes only after DEB_CYCLES equal samples
         always_comb begin
            d_next    = d_reg;
            d_next.s1 = raw[i];
            d_next.s2 = d_reg.s1;
            if (d_reg.s2 == d_reg.q) begin
               d_next.cnt = 3'h0;
            end else if (d_reg.cnt == DEB_LAST) begin
               d_next.q   = d_reg.s2;
               d_next.cnt = 3'h0;
            end else begin
               d_next.cnt = d_reg.cnt + 3'h1;
            end
         end

         // Filter state
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               d_reg <= '{s1: RST_VAL[i], s2: RST_VAL[i], cnt: 3'h0,
                          q: RST_VAL[i]};
            end else begin
               d_reg <= d_next;
            end
         end
         assign stable[i] = d_reg.q;
      end
   endgenerate
endmodule // crc_debounce

// ---- crc_mem.sv ----
// Stored settings memory, one write port and a registered read port
module crc_mem
   import crc_pkg::*;
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Write port
   input  wire logic             we,
   input  wire logic [4:0]       waddr,
   input  wire logic [MEM_W-1:0] wdata,
   // Read port
   input  wire logic             re,
   input  wire logic [4:0]       raddr,
   output      logic [MEM_W-1:0] rdata
);
   crc_mem_t m_reg;
   crc_mem_t m_next;

   // Write and read update
   always_comb begin
      m_next = m_reg;
      if (we) begin
         m_next.mem[waddr] = wdata;
      end
      if (re) begin
         m_next.rdata = m_reg.mem[raddr];
      end
   end

   // Storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end
   assign rdata = m_reg.rdata;
endmodule // crc_mem

// ---- crc_top.sv ----
// Converter remote control: message parser, service request, band lock
// Function
// - Combined set updates frequency and attenuation, mute left as is.
// - Message is C, F, seven or eight digits, T, three digits.
// - Any new alarm failure asserts the service request line while enabled.
// - Poll byte: bit 6 set, bits 7,5,4,3 zero, low three fault index.
// - Fault index is binary number of the alarm line, first is zero.
// - Six fault inputs: synth, LO one, LO two, supply, level, level.
// - Poll without pending request repeats last index, bit 6 zero.
// - Stored enable gates the service request; disabled means none.
// - Band inputs sampled always; a band is chosen by grounding it.
// - Valid band retunes to last frequency set in that band.
// - Frequency settings accepted only inside selected band limits.
// - Out-of-band local entry rejected with out-of-range response.
// - No band or several bands mute and block all frequency settings.
// - Contact commands and status outputs are active low.
// - Command weights 1,2,4,8,10,20 sum to the location number.
// - Contact command accepted only in remote with cable line low.
// - Accepted command recalls location and echoes weights low.
// - Status held until cable released, local, or new valid command.
module crc_top
   import crc_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire crc_apb_req_t      apb_req,
   output      crc_apb_rsp_t      apb_rsp,
   // Contact inputs, active low
   input  wire logic [2:0]        band_select_input_n,
   input  wire logic [5:0]        bcd_cmd_n,
   input  wire logic              cable_sup_n,
   // Component fault lines, high on failure
   input  wire logic [5:0]        alarm_in,
   // Service request, contact status, converter settings
   output      logic              srq_out,
   output      logic [5:0]        bcd_status_n,
   output      logic [FREQ_W-1:0] freq_out,
   output      logic [ATT_W-1:0]  atten_out,
   output      logic              mute_out
);
   crc_state_t        s_reg;
   crc_state_t        s_next;
   logic [9:0]        cont;
   logic [5:0]        alarm;
   logic [MEM_W-1:0]  mem_rdata;
   logic [31:0]       rd_word;
   logic              addr_hit;
   logic              acc;
   logic              wr_done;
   logic              poll_rd;
   logic              cmd_wr;
   logic              lfreq_wr;
   logic [7:0]        wchar;
   logic              is_dig;
   logic [3:0]        dig;
   logic              cmd_ok;
   logic              set_req;
   logic [FREQ_W-1:0] set_freq;
   logic [ATT_W-1:0]  set_att;
   logic              f_ok;
   logic [2:0]        band_act;
   logic              one;
   logic [1:0]        idx;
   logic              band_chg;
   logic [5:0]        new_fail;
   logic              srq_en;
   logic [5:0]        bcd_b;
   logic [5:0]        bcd_val;
   logic              bcd_valid;
   logic              link_up;
   logic              accept;
   logic              mem_we;

   // Contact inputs filtered, idle high
   crc_debounce #(.W(10), .RST_VAL(10'h3FF)) u_contact (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({cable_sup_n, bcd_cmd_n, band_select_input_n}),
      .stable  (cont)
   );

   // Fault lines synchronised the same way
   crc_debounce #(.W(6), .RST_VAL(6'h00)) u_alarm (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     (alarm_in),
      .stable  (alarm)
   );

   // Stored settings for contact recall
   crc_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (mem_we),
      .waddr   (s_reg.mem_sel),
      .wdata   ({s_reg.mem_freq, apb_req.pwdata[ATT_W-1:0]}),
      .re      (accept),
      .raddr   (bcd_val[4:0]),
      .rdata   (mem_rdata)
   );

   // Frequency inside a band's limits
   function automatic logic in_band(logic [FREQ_W-1:0] f,
                                    logic [1:0] b);
      in_band = f >= BAND_LO[b] && f <= BAND_HI[b];
   endfunction

   // Lowest failing line number
   function automatic logic [2:0] first_fail(logic [5:0] v);
      first_fail = 3'h0;
      for (int k = 5; k >= 0; k--) begin
         if (v[k]) begin
            first_fail = 3'(k);
         end
      end
   endfunction

   // Read data and address decode
   always_comb begin
      addr_hit = 1'b1;
      rd_word  = 32'h0000_0000;
      if (apb_req.paddr == ADDR_CTRL) begin
         rd_word[2:0] = s_reg.ctrl;
      end else if (apb_req.paddr == ADDR_CMD) begin
         rd_word[1:0] = s_reg.pstate;
      end else if (apb_req.paddr == ADDR_FREQ) begin
         rd_word[FREQ_W-1:0] = s_reg.freq;
      end else if (apb_req.paddr == ADDR_ATT) begin
         rd_word[ATT_W-1:0] = s_reg.att;
      end else if (apb_req.paddr == ADDR_STAT) begin
         rd_word[11:0] = {s_reg.bcd_loc, s_reg.band_idx, s_reg.band_ok,
                          s_reg.mute, s_reg.cmd_err, 1'b0, s_reg.srq};
      end else if (apb_req.paddr == ADDR_POLL) begin
         rd_word[7:0] = {1'b0, s_reg.srq, 3'h0, s_reg.fault_idx};
      end else if (apb_req.paddr == ADDR_LFREQ ||
                   apb_req.paddr == ADDR_MATT) begin
         rd_word = 32'h0000_0000;
      end else if (apb_req.paddr == ADDR_RESP) begin
         rd_word[7:0] = s_reg.resp;
      end else if (apb_req.paddr == ADDR_MSEL) begin
         rd_word[4:0] = s_reg.mem_sel;
      end else if (apb_req.paddr == ADDR_MFREQ) begin
         rd_word[FREQ_W-1:0] = s_reg.mem_freq;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // Bus decode and contact decode
   always_comb begin
      acc      = apb_req.psel & apb_req.penable;
      wr_done  = acc & s_reg.rsp.pready & apb_req.pwrite;
      poll_rd  = acc & s_reg.rsp.pready & ~apb_req.pwrite &
                 apb_req.paddr == ADDR_POLL;
      cmd_wr   = wr_done & apb_req.paddr == ADDR_CMD;
      lfreq_wr = wr_done & apb_req.paddr == ADDR_LFREQ;
      mem_we   = wr_done & apb_req.paddr == ADDR_MATT;
      wchar    = apb_req.pwdata[7:0];
      is_dig   = wchar >= CH_0 && wchar <= CH_9;
      dig      = 4'(wchar - CH_0);
      srq_en   = s_reg.ctrl[CTRL_SRQ_EN_BIT];
      new_fail = alarm & ~s_reg.alarm_prev;
      band_act = ~cont[2:0];
      one      = $onehot(band_act);
      idx      = band_act[2] ? 2'h2 : (band_act[1] ? 2'h1 : 2'h0);
      band_chg = one && (!s_reg.band_ok || idx != s_reg.band_idx);
      bcd_b    = ~cont[8:3];
      bcd_val  = {2'b00, bcd_b[3:0]} + (bcd_b[4] ? 6'd10 : 6'd0) +
                 (bcd_b[5] ? 6'd20 : 6'd0);
      bcd_valid = bcd_b[3:0] <= 4'h9 && bcd_val >= 6'd1 &&
                  bcd_val <= 6'd31;
      link_up  = s_reg.ctrl[CTRL_REMOTE_BIT] & ~cont[9];
      accept   = link_up && bcd_valid &&
                 bcd_val[4:0] != s_reg.bcd_loc;
   end

   // Next state of the whole block
   always_comb begin
      s_next  = s_reg;
      cmd_ok  = 1'b0;
      // APB answer one cycle into the access phase
      s_next.rsp.pready = acc & ~s_reg.rsp.pready;
      if (acc & ~s_reg.rsp.pready) begin
         s_next.rsp.prdata  = rd_word;
         s_next.rsp.pslverr = ~addr_hit;
      end
      // Register writes
      if (wr_done) begin
         if (apb_req.paddr == ADDR_CTRL) begin
            s_next.ctrl = apb_req.pwdata[2:0];
         end else if (apb_req.paddr == ADDR_STAT &&
                      apb_req.pwdata[STAT_ERR_BIT]) begin
            s_next.cmd_err = 1'b0;
         end else if (apb_req.paddr == ADDR_MSEL) begin
            s_next.mem_sel = apb_req.pwdata[4:0];
         end else if (apb_req.paddr == ADDR_MFREQ) begin
            s_next.mem_freq = apb_req.pwdata[FREQ_W-1:0];
         end
      end
      // Combined set message parser
      if (cmd_wr) begin
         case (s_reg.pstate)
            P_IDLE: begin
               if (wchar == CH_C) begin
                  s_next.pstate = P_CMD;
               end
            end
            P_CMD: begin
               s_next.pstate = wchar == CH_F ? P_FREQ : P_IDLE;
               s_next.fcnt   = 4'h0;
               s_next.fbuf   = '0;
               s_next.cmd_err = wchar != CH_F;
            end
            P_FREQ: begin
               if (is_dig && s_reg.fcnt < FDIG_MAX) begin
                  s_next.fbuf = FREQ_W'(s_reg.fbuf * 27'd10 + dig);
                  s_next.fcnt = s_reg.fcnt + 4'h1;
               end else if (wchar == CH_T && s_reg.fcnt >= FDIG_MIN) begin
                  s_next.pstate = P_ATT;
                  s_next.acnt   = 2'h0;
                  s_next.abuf   = '0;
               end else begin
                  s_next.pstate  = P_IDLE;
                  s_next.cmd_err = 1'b1;
               end
            end
            P_ATT: begin
               if (is_dig) begin
                  s_next.abuf = ATT_W'(s_reg.abuf * 10'd10 + dig);
                  s_next.acnt = s_reg.acnt + 2'h1;
                  if (s_reg.acnt == ADIG_LAST) begin
                     cmd_ok        = 1'b1;
                     s_next.pstate = P_IDLE;
                  end
               end else begin
                  s_next.pstate  = P_IDLE;
                  s_next.cmd_err = 1'b1;
               end
            end
            default: s_next.pstate = P_IDLE;
         endcase
      end
      // Pick one frequency source per cycle, recall waits its turn
      set_req  = cmd_ok | lfreq_wr | s_reg.recall_pend;
      set_freq = s_reg.freq;
      set_att  = s_reg.att;
      if (cmd_ok) begin
         set_freq = s_reg.fbuf;
         set_att  = s_next.abuf;
      end else if (lfreq_wr) begin
         set_freq = apb_req.pwdata[FREQ_W-1:0];
      end else if (s_reg.recall_pend) begin
         set_freq = mem_rdata[MEM_W-1:ATT_W];
         set_att  = mem_rdata[ATT_W-1:0];
         s_next.recall_pend = 1'b0;
      end
      // Band lock-out gate on every setting
      f_ok = s_reg.band_ok && in_band(set_freq, s_reg.band_idx);
      if (set_req && f_ok) begin
         s_next.freq = set_freq;
         s_next.att  = set_att;
         s_next.band_last[s_reg.band_idx] = set_freq;
      end
      if (lfreq_wr) begin
         s_next.resp = f_ok ? RESP_OK : RESP_RANGE;
      end
      if (cmd_ok && !f_ok) begin
         s_next.cmd_err = 1'b1;
      end
      // Band selection, retune, and error mute
      s_next.band_ok = one;
      if (band_chg) begin
         s_next.band_idx = idx;
         s_next.freq     = s_reg.band_last[idx];
      end
      s_next.mute = ~one | s_reg.ctrl[CTRL_MUTE_BIT];
      // Service request, set wins over the poll clear
      s_next.alarm_prev = alarm;
      if (poll_rd && s_reg.rsp.prdata[POLL_RQS_BIT]) begin
         s_next.srq = 1'b0;
      end
      if (!srq_en) begin
         s_next.srq = 1'b0;
      end else if (|new_fail) begin
         if (!s_next.srq) begin
            s_next.fault_idx = first_fail(new_fail);
         end
         s_next.srq = 1'b1;
      end
      // Contact command accept, echo and hold
      if (!link_up) begin
         s_next.bcd_loc    = 5'h00;
         s_next.bcd_stat_n = 6'h3F;
      end else if (accept) begin
         s_next.bcd_loc     = bcd_val[4:0];
         s_next.bcd_stat_n  = ~bcd_b;
         s_next.recall_pend = 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg            <= '0;
         s_reg.ctrl       <= CTRL_RESET;
         s_reg.pstate     <= P_IDLE;
         s_reg.band_last  <= BAND_LO;
         s_reg.mute       <= 1'b1;
         s_reg.bcd_stat_n <= 6'h3F;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign apb_rsp      = s_reg.rsp;
   assign srq_out      = s_reg.srq;
   assign bcd_status_n = s_reg.bcd_stat_n;
   assign freq_out     = s_reg.freq;
   assign atten_out    = s_reg.att;
   assign mute_out     = s_reg.mute;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   combo_set_a: assert property (cmd_ok && f_ok && !band_chg |=>
      freq_out == $past(s_reg.fbuf) && atten_out == $past(s_next.abuf))
      else $error("combined set did not load both settings");
   srq_raise_a: assert property (srq_en && |new_fail |=> srq_out)
      else $error("failure did not raise service request");
   poll_shape_a: assert property (poll_rd |->
      !apb_rsp.prdata[7] && apb_rsp.prdata[5:3] == 3'h0)
      else $error("poll byte fixed bits wrong");
   fault_index_a: assert property (
      srq_en && |new_fail && !s_reg.srq && !poll_rd |=>
      s_reg.fault_idx == first_fail($past(new_fail)))
      else $error("fault index wrong");
   poll_idle_a: assert property (poll_rd && !apb_rsp.prdata[6] |->
      apb_rsp.prdata[2:0] == s_reg.fault_idx)
      else $error("idle poll index differs");
   srq_off_a: assert property (!srq_en |=> !srq_out)
      else $error("service request while disabled");
   band_retune_a: assert property (band_chg |=>
      freq_out == $past(s_reg.band_last[idx]))
      else $error("band change did not retune");
   local_range_a: assert property (lfreq_wr && !f_ok |=>
      s_reg.resp == RESP_RANGE)
      else $error("out of band entry not flagged");
   band_block_a: assert property (!s_reg.band_ok && !one |->
      mute_out ##1 $stable(freq_out))
      else $error("band error did not mute and block");
   bcd_echo_a: assert property (accept |=>
      bcd_status_n == $past(~bcd_b))
      else $error("status echo wrong");
   bcd_drop_a: assert property (!link_up |=> bcd_status_n == 6'h3F)
      else $error("status held after release");

   combo_cov: cover property (cmd_ok && f_ok);
   recall_cov: cover property (accept ##1 s_reg.recall_pend);
   poll_cov: cover property (srq_out ##[1:20] poll_rd);
endmodule // crc_top

// ---- crc_contact_model.sv ----
// Far-side contact closures: band, weighted command and cable lines
module crc_contact_model (
   // Closures requested by the bench
   input  wire logic [2:0] band_on,
   input  wire logic [4:0] loc,
   input  wire logic       cable_on,
   // Contact lines, low when grounded
   output      logic [2:0] band_select_input_n,
   output      logic [5:0] bcd_cmd_n,
   output      logic       cable_sup_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Grounding a line pulls it low
   assign band_select_input_n = ~band_on;
   assign cable_sup_n = ~cable_on;
   // Tens as weights 10 and 20, units as weights 1 to 8
   assign bcd_cmd_n = ~{2'(loc / 5'd10), 4'(loc % 5'd10)};
endmodule  // crc_contact_model

// ---- tb_converter_remote_control.sv ----
// Self-checking bench for the converter remote control
module tb_converter_remote_control;
   timeunit 1ns;
   timeprecision 1ns;
   import crc_pkg::*;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   crc_apb_req_t      apb_req = '0;
   crc_apb_rsp_t      apb_rsp;
   logic [2:0]        band_on = 3'h1;
   logic [4:0]        loc = 5'h00;
   logic              cable_on = 1'b0;
   logic [5:0]        alarm_in = 6'h00;
   logic [2:0]        band_n;
   logic [5:0]        bcd_n;
   logic              cable_n;
   logic              srq_out;
   logic [5:0]        bcd_status_n;
   logic [FREQ_W-1:0] freq_out;
   logic [ATT_W-1:0]  atten_out;
   logic              mute_out;
   logic [31:0]       rd;
   logic              err;
   int                failures = 0;
   int                cmp_count = 0;
   // Clock at 10 MHz
   always #50 pclk = ~pclk;
   crc_top u_crc_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .band_select_input_n(band_n), .bcd_cmd_n(bcd_n),
      .cable_sup_n(cable_n), .alarm_in(alarm_in), .srq_out(srq_out),
      .bcd_status_n(bcd_status_n), .freq_out(freq_out),
      .atten_out(atten_out), .mute_out(mute_out));
   crc_contact_model u_crc_contact_model (.band_on(band_on), .loc(loc),
      .cable_on(cable_on), .band_select_input_n(band_n), .bcd_cmd_n(bcd_n),
      .cable_sup_n(cable_n));
   // Verdict and end of run
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; pready, read data and error taken at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (n == 20) begin
         failures++;
         summarize();
      end
      rd  = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      // Release at the same edge that completed the transfer
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   // Combined set, one character per write
   task automatic send(input string s);
      foreach (s[i]) apb(1'b1, ADDR_CMD, {24'h00_0000, s[i]});
   endtask
   // Let contact filters settle
   task automatic settle();
      repeat (12) @(posedge pclk);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk("mute", 32'h1, 32'(mute_out));
      chk("status", 32'h3F, 32'(bcd_status_n));
      settle();
      chk("unmute", 32'h0, 32'(mute_out));
      chk("freq", 32'(BAND_LO[0]), 32'(freq_out));
      send("CF13800000T123");
      repeat (2) @(posedge pclk);
      chk("freq", 32'h00D2_9240, 32'(freq_out));
      chk("att", 32'h0000_007B, 32'(atten_out));
      chk("mute", 32'h0, 32'(mute_out));
      send("CF1380000T050");
      repeat (2) @(posedge pclk);
      chk("att", 32'h0000_007B, 32'(atten_out));
      chk("freq", 32'h00D2_9240, 32'(freq_out));
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("cmd_err", 32'h1, 32'(rd[STAT_ERR_BIT]));
      apb(1'b1, ADDR_LFREQ, 32'h00DA_3360);
      apb(1'b0, ADDR_RESP, 32'h0);
      chk("resp", 32'(RESP_RANGE), rd);
      chk("freq", 32'h00D2_9240, 32'(freq_out));
      band_on <= 3'h2;
      settle();
      chk("freq", 32'(BAND_LO[1]), 32'(freq_out));
      band_on <= 3'h1;
      settle();
      chk("freq", 32'h00D2_9240, 32'(freq_out));
      band_on <= 3'h3;
      settle();
      chk("mute", 32'h1, 32'(mute_out));
      send("CF13900000T010");
      repeat (2) @(posedge pclk);
      chk("att", 32'h0000_007B, 32'(atten_out));
      chk("freq", 32'h00D2_9240, 32'(freq_out));
      band_on <= 3'h1;
      apb(1'b1, ADDR_CTRL, 32'h1);
      alarm_in <= 6'h04;
      settle();
      chk("srq", 32'h1, 32'(srq_out));
      apb(1'b0, ADDR_POLL, 32'h0);
      chk("poll", 32'h42, rd);
      chk("pslverr", 32'h0, 32'(err));
      apb(1'b0, ADDR_POLL, 32'h0);
      chk("poll", 32'h02, rd);
      apb(1'b1, ADDR_CTRL, 32'h2);
      alarm_in <= 6'h0C;
      settle();
      chk("srq", 32'h0, 32'(srq_out));
      // Stage a setting in location 31 for the contact recall
      apb(1'b1, ADDR_MSEL, 32'h0000_001F);
      apb(1'b1, ADDR_MFREQ, 32'h00D4_18E0);
      apb(1'b1, ADDR_MATT, 32'h0000_0055);
      cable_on <= 1'b1;
      loc <= 5'd31;
      settle();
      chk("status", 32'h0E, 32'(bcd_status_n));
      chk("freq", 32'h00D4_18E0, 32'(freq_out));
      chk("att", 32'h0000_0055, 32'(atten_out));
      loc <= 5'd0;
      settle();
      chk("status", 32'h0E, 32'(bcd_status_n));
      loc <= 5'd12;
      settle();
      chk("status", 32'h2D, 32'(bcd_status_n));
      cable_on <= 1'b0;
      settle();
      chk("status", 32'h3F, 32'(bcd_status_n));
      loc <= 5'd7;
      settle();
      chk("status", 32'h3F, 32'(bcd_status_n));
      summarize();
   end
endmodule  // tb_converter_remote_control
